// file: vdc_pkg.sv
package vdc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CAPTION_STATUS = 8'h1A;
  localparam logic [7:0] OFS_CAPTION_DATA = 8'h1B;
  localparam logic [7:0] OFS_STANDARD_SELECTION = 8'h1C;
  localparam logic [7:0] OFS_STANDARD_RECOGNITION = 8'h1D;
  localparam logic [7:0] OFS_GENERAL_PURPOSE_PORT = 8'h1E;
  localparam logic [7:0] OFS_TEST_CONTROL = 8'h1F;
  localparam logic [7:0] OFS_CLAMP_TIMING = 8'h20;
  localparam logic [7:0] OFS_GAIN_LOOP_CONTROL = 8'h21;
  localparam logic [7:0] OFS_MANUAL_GAIN_LOW = 8'h22;
  // ==========================================================
  // field positions
  localparam int BIT_DETECTION_ACTIVE = 7;
  localparam int BIT_SHADOW_DISABLE = 3;
  localparam int BIT_DETECTION_TRIGGER = 7;
  localparam int BIT_MANUAL_GAIN_MSB = 0;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CAPTION_DATA = 8'h80;
  localparam logic [2:0] RST_STANDARD = 3'h0;
  localparam logic [6:0] RST_RECOGNITION = 7'h00;
  localparam logic [3:0] RST_GP_OUT = 4'h0;
  localparam logic [7:0] RST_TEST_CONTROL = 8'h00;
  localparam logic [3:0] RST_CLAMP_END = 4'hA;
  localparam logic [3:0] RST_CLAMP_START = 4'h0;
  localparam logic [3:0] RST_NORMAL_MAX = 4'h2;
  localparam logic [2:0] RST_PEAK_GAIN = 3'h1;
  localparam logic [8:0] RST_MANUAL_GAIN = 9'h0F0;
  // ==========================================================
  // timing: clamp steps and detection run length
  localparam int CLAMP_STEP_CLOCKS = 8;
  localparam int DETECT_TIME_US = 100;
  localparam int CLOCK_MHZ = 20;
  localparam int DETECT_CYCLES = DETECT_TIME_US * CLOCK_MHZ;
  localparam logic [2:0] STD_AUTO = 3'h7;
  localparam logic [2:0] STD_INVALID = 3'h7;
  // ==========================================================
  // test codes
  typedef enum logic [2:0]
  {
    VDC_TEST_NONE = 3'h0,
    VDC_TEST_ANALOG = 3'h1,
    VDC_TEST_DIGITAL1 = 3'h2,
    VDC_TEST_ANALOG_EXT = 3'h3,
    VDC_TEST_DIGITAL2 = 3'h4,
    VDC_TEST_CAPTION = 3'h5,
    VDC_TEST_CHROMA = 3'h6,
    VDC_TEST_DAC = 3'h7
  } vdc_test_e;
endpackage : vdc_pkg

// file: vdc_test_if.sv
`timescale 1ns/10ps
interface vdc_test_if;
  import vdc_pkg::*;
  logic [7:0] code;
  logic [9:0] luma_adc;
  logic [9:0] chroma_adc;
  logic [7:0] luma_out;
  logic [7:0] chroma_out;
  logic [5:0] sync_out;
  logic bandgap;
  logic vsync_delayed;
  logic eight_bit_mode;
  logic [3:0] gp_out;
  logic [15:0] vd_data;
  logic ha_in;
  logic hs_in;
  logic va_in;
  logic vs_in;
  logic [15:0] vd_o;
  logic [15:0] vd_oe_n;
  logic ha_o;
  logic hs_o;
  logic va_o;
  logic vs_o;
  logic [5:0] tpin_o;
  logic [5:0] tpin_oe_n;
  logic sel_ext_chroma;
  logic take_vd_chroma;
  modport ctrl (output code, luma_adc, chroma_adc, luma_out, chroma_out, sync_out, bandgap, vsync_delayed,
    eight_bit_mode, gp_out, vd_data, ha_in, hs_in, va_in, vs_in,
    input vd_o, vd_oe_n, ha_o, hs_o, va_o, vs_o, tpin_o, tpin_oe_n, sel_ext_chroma, take_vd_chroma);
  modport mux (input code, luma_adc, chroma_adc, luma_out, chroma_out, sync_out, bandgap, vsync_delayed,
    eight_bit_mode, gp_out, vd_data, ha_in, hs_in, va_in, vs_in,
    output vd_o, vd_oe_n, ha_o, hs_o, va_o, vs_o, tpin_o, tpin_oe_n, sel_ext_chroma, take_vd_chroma);
endinterface : vdc_test_if

// file: vdc_pin_mux.sv
`timescale 1ns/10ps
module vdc_pin_mux
(
  vdc_test_if.mux t
);
  import vdc_pkg::*;
  wire [2:0] code_low = t.code[2:0];
  wire code_known = (t.code[7:3] == 5'h00);
  wire luma_route = code_known && (code_low == VDC_TEST_ANALOG || code_low == VDC_TEST_ANALOG_EXT);
  wire chroma_route = luma_route || (code_known && code_low == VDC_TEST_CHROMA);
  wire dac_mode = code_known && (code_low == VDC_TEST_DAC);
  wire dig2 = code_known && (code_low == VDC_TEST_DIGITAL2);
  wire [7:0] vd_hi = luma_route ? t.luma_adc[9:2] : t.luma_out;
  wire [7:0] vd_lo = chroma_route ? t.chroma_adc[9:2] : (dac_mode ? t.chroma_out
    : (t.eight_bit_mode ? {4'h0, t.gp_out} : t.chroma_out));
  // in 8-bit mode the upper nibble of the low byte is an input unless ADC routing or the DAC test drives it; digital mode 2 frees the whole low byte
  wire [3:0] caption_byte_half_oe_n = (dig2 || (t.eight_bit_mode && !chroma_route && !dac_mode)) ? 4'hF : 4'h0;
  wire [3:0] lo_lo_oe_n = dig2 ? 4'hF : 4'h0;
  assign t.vd_o = {vd_hi, vd_lo};
  assign t.vd_oe_n = {8'h00, caption_byte_half_oe_n, lo_lo_oe_n};
  assign t.ha_o = luma_route ? t.luma_adc[1] : (dac_mode ? t.bandgap : t.ha_in);
  assign t.hs_o = luma_route ? t.luma_adc[0] : t.hs_in;
  assign t.va_o = chroma_route ? t.chroma_adc[1] : (dac_mode ? t.vsync_delayed : t.va_in);
  assign t.vs_o = chroma_route ? t.chroma_adc[0] : t.vs_in;
  assign t.tpin_o = t.sync_out;
  assign t.tpin_oe_n = dac_mode ? 6'h00 : 6'h3F;
  assign t.sel_ext_chroma = code_known && (code_low == VDC_TEST_ANALOG_EXT);
  assign t.take_vd_chroma = dig2;
endmodule : vdc_pin_mux

// file: vdc_ctrl_regs.sv
// Added by the designer: strobed register access.
`timescale 1ns/10ps
// Summary of operation
// - caption data reads the caption byte, 80h after reset, read only.
// - selection bit 7 shows 1 while a detection run is in progress.
// - selection bits 6-4 show the applied standard, 7 meaning not valid.
// - selection bits 2-0 force a standard; 7 selects automatic detection; reset 0.
// - selection bit 3 low loads shadow values by standard; high disables them.
// - writing 1 to recognition bit 7 starts detection; the bit self-clears.
// - recognition bits 0-6 enable recognition of each standard; reset 0.
// - in 8-bit mode port bits 7-4 read bus lines 7-4.
// - in 8-bit mode port bits 3-0 drive bus lines 3-0 outside test codes 1, 3, 4, 6 and 7; reset 0.
// - test code 1 routes luma and chroma ADC results to sync pins and bus.
// - test code 2 takes an 8-bit sync test input from eight test pins.
// - test code 3 is code 1 with chroma ADC from differential test inputs.
// - test code 4 adds chroma input on bus bits 7-0, in either output format.
// - code 5 is caption test; code 6 exposes only the chroma ADC result.
// - code 7 shows sync on test pins, bandgap and delayed vsync on active pins.
// - clamp timing bits 7-4 set clamp end in 8-clock steps; reset A.
// - clamp timing bits 3-0 set clamp start in 8-clock steps from position; reset 0.
// - gain bits 7-4 limit normal loop correction (2); bits 3-1 peak gain (1).
// - gain bit 0 is manual gain MSB, used with loop disabled; reset 0.
// - manual gain low register holds the low eight gain bits; reset F0h.
// - caption status bit 0 shows low (0) or high (1) caption byte.
module vdc_ctrl_regs
#(
  parameter int DETECT_LEN = vdc_pkg::DETECT_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] caption_byte,
  input wire logic caption_byte_half,
  input wire logic [6:0] caption_status_other,
  input wire logic [6:0] detected_standard_valid,
  input wire logic [2:0] detected_standard,
  input wire logic detect_done,
  input wire logic output_format_register,
  input wire logic [15:0] video_data_bus_in,
  input wire logic [7:0] test_select_pin_in,
  input wire logic [9:0] luma_adc,
  input wire logic [9:0] chroma_adc,
  input wire logic [7:0] luma_out,
  input wire logic [7:0] chroma_out,
  input wire logic [5:0] sync_test_out,
  input wire logic bandgap_output,
  input wire logic delayed_vertical_sync,
  input wire logic ha_core,
  input wire logic hs_core,
  input wire logic va_core,
  input wire logic vs_core,
  output logic [15:0] video_data_bus_out,
  output logic [15:0] video_data_bus_oe_n,
  output logic horizontal_active_pin,
  output logic hsync_pin,
  output logic vertical_active_pin,
  output logic vsync_pin,
  output logic [5:0] test_pin_out,
  output logic [5:0] test_pin_oe_n,
  output logic chroma_from_test_inputs,
  output logic chroma_from_bus,
  output logic [7:0] sync_test_input,
  output logic caption_test_mode,
  output logic detection_active_flag,
  output logic [2:0] current_standard,
  output logic shadow_load_enable,
  output logic [3:0] clamp_end_time,
  output logic [3:0] clamp_start_time,
  output logic [3:0] normal_loop_max_correction,
  output logic [2:0] peak_loop_gain,
  output logic [8:0] manual_gain_value
);
  import vdc_pkg::*;
  // ==========================================================
  // pin synchronisers
  logic [15:0] vd_meta;
  logic [15:0] vd_sync;
  logic [7:0] tsel_meta;
  logic [7:0] tsel_sync;
  logic fmt_meta;
  logic fmt_sync;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vd_meta <= 16'h0000;
      vd_sync <= 16'h0000;
      tsel_meta <= 8'h00;
      tsel_sync <= 8'h00;
    end
    else
    begin
      vd_meta <= video_data_bus_in;
      vd_sync <= vd_meta;
      tsel_meta <= test_select_pin_in;
      tsel_sync <= tsel_meta;
    end
  end
  // format bit comes from our own clock domain but passes two flops, so mode changes lag by two cycles
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fmt_meta <= 1'b1;
      fmt_sync <= 1'b1;
    end
    else
    begin
      fmt_meta <= output_format_register;
      fmt_sync <= fmt_meta;
    end
  end
  wire eight_bit_mode = !fmt_sync;
  // ==========================================================
  // register state
  typedef enum logic [1:0]
  {
    VDC_DET_IDLE = 2'b01,
    VDC_DET_RUN = 2'b10
  } vdc_det_e;
  vdc_det_e det_state;
  vdc_det_e next_det_state;
  logic [15:0] det_count;
  logic [7:0] caption_data;
  logic half_flag;
  logic [2:0] standard;
  logic shadow_disable;
  logic [6:0] recognition;
  logic [3:0] gp_out;
  logic [7:0] test_control;
  logic [2:0] applied;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit
  wire wr_sel = reg_wr && hit(reg_addr, OFS_STANDARD_SELECTION);
  wire wr_rec = reg_wr && hit(reg_addr, OFS_STANDARD_RECOGNITION);
  wire wr_gp = reg_wr && hit(reg_addr, OFS_GENERAL_PURPOSE_PORT);
  wire wr_test = reg_wr && hit(reg_addr, OFS_TEST_CONTROL);
  wire wr_clamp = reg_wr && hit(reg_addr, OFS_CLAMP_TIMING);
  wire wr_gain = reg_wr && hit(reg_addr, OFS_GAIN_LOOP_CONTROL);
  wire wr_mgain = reg_wr && hit(reg_addr, OFS_MANUAL_GAIN_LOW);
  wire trigger = wr_rec && reg_wdata[BIT_DETECTION_TRIGGER];
  wire auto_mode = (standard == STD_AUTO);
  // ==========================================================
  // detection sequencer: a run lasts until the detector reports or the timeout
  wire run_end = detect_done || (det_count == 16'(DETECT_LEN - 1));
  always_comb
  begin
    next_det_state = det_state;
    case (det_state)
      VDC_DET_IDLE:
        if (trigger)
          next_det_state = VDC_DET_RUN;
      VDC_DET_RUN:
        if (run_end)
          next_det_state = VDC_DET_IDLE;
      default:
        next_det_state = VDC_DET_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      det_state <= VDC_DET_IDLE;
      det_count <= 16'h0000;
    end
    else
    begin
      det_state <= next_det_state;
      det_count <= (det_state == VDC_DET_RUN) ? det_count + 16'h0001 : 16'h0000;
    end
  end
  // a detected standard counts only if its recognition bit is set
  wire det_ok = recognition[detected_standard] && (detected_standard != STD_INVALID);
  wire [2:0] next_applied = !auto_mode ? standard : ((detect_done && det_state == VDC_DET_RUN)
    ? (det_ok ? detected_standard : STD_INVALID) : applied);
  // ==========================================================
  // writable fields
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      standard <= RST_STANDARD;
      shadow_disable <= 1'b0;
      recognition <= RST_RECOGNITION;
      gp_out <= RST_GP_OUT;
      test_control <= RST_TEST_CONTROL;
      clamp_end_time <= RST_CLAMP_END;
      clamp_start_time <= RST_CLAMP_START;
      normal_loop_max_correction <= RST_NORMAL_MAX;
      peak_loop_gain <= RST_PEAK_GAIN;
      manual_gain_value <= RST_MANUAL_GAIN;
      applied <= RST_STANDARD;
    end
    else
    begin
      applied <= next_applied;
      if (wr_sel)
      begin
        standard <= reg_wdata[2:0];
        shadow_disable <= reg_wdata[BIT_SHADOW_DISABLE];
      end
      if (wr_rec)
        recognition <= reg_wdata[6:0];
      if (wr_gp)
        gp_out <= reg_wdata[3:0];
      if (wr_test)
        test_control <= reg_wdata;
      if (wr_clamp)
      begin
        clamp_end_time <= reg_wdata[7:4];
        clamp_start_time <= reg_wdata[3:0];
      end
      if (wr_gain)
      begin
        normal_loop_max_correction <= reg_wdata[7:4];
        peak_loop_gain <= reg_wdata[3:1];
        manual_gain_value[8] <= reg_wdata[BIT_MANUAL_GAIN_MSB];
      end
      if (wr_mgain)
        manual_gain_value[7:0] <= reg_wdata;
    end
  end
  // caption byte is latched by the decoder core side, never by software
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      caption_data <= RST_CAPTION_DATA;
      half_flag <= 1'b0;
    end
    else
    begin
      caption_data <= caption_byte;
      half_flag <= caption_byte_half;
    end
  end
  // ==========================================================
  // read path
  wire [7:0] rd_sel = {(det_state == VDC_DET_RUN), applied, shadow_disable, standard};
  wire [7:0] rd_gp = {(eight_bit_mode ? vd_sync[7:4] : 4'h0), gp_out};
  wire [7:0] rd_mux =
    hit(reg_addr, OFS_CAPTION_STATUS) ? {caption_status_other, half_flag} :
    hit(reg_addr, OFS_CAPTION_DATA) ? caption_data :
    hit(reg_addr, OFS_STANDARD_SELECTION) ? rd_sel :
    hit(reg_addr, OFS_STANDARD_RECOGNITION) ? {1'b0, recognition} :
    hit(reg_addr, OFS_GENERAL_PURPOSE_PORT) ? rd_gp :
    hit(reg_addr, OFS_TEST_CONTROL) ? test_control :
    hit(reg_addr, OFS_CLAMP_TIMING) ? {clamp_end_time, clamp_start_time} :
    hit(reg_addr, OFS_GAIN_LOOP_CONTROL) ? {normal_loop_max_correction, peak_loop_gain, manual_gain_value[8]} :
    hit(reg_addr, OFS_MANUAL_GAIN_LOW) ? manual_gain_value[7:0] : 8'h00;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end
  // ==========================================================
  // test pin routing
  vdc_test_if tif();
  assign tif.code = test_control;
  assign tif.luma_adc = luma_adc;
  assign tif.chroma_adc = chroma_adc;
  assign tif.luma_out = luma_out;
  assign tif.chroma_out = chroma_out;
  assign tif.sync_out = sync_test_out;
  assign tif.bandgap = bandgap_output;
  assign tif.vsync_delayed = delayed_vertical_sync;
  assign tif.eight_bit_mode = eight_bit_mode;
  assign tif.gp_out = gp_out;
  assign tif.vd_data = vd_sync;
  assign tif.ha_in = ha_core;
  assign tif.hs_in = hs_core;
  assign tif.va_in = va_core;
  assign tif.vs_in = vs_core;
  vdc_pin_mux u_mux
  (
    .t(tif.mux)
  );
  wire code_dig = (test_control == 8'h02) || (test_control == 8'h04);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      video_data_bus_out <= 16'h0000;
      video_data_bus_oe_n <= 16'h0000;
      horizontal_active_pin <= 1'b0;
      hsync_pin <= 1'b0;
      vertical_active_pin <= 1'b0;
      vsync_pin <= 1'b0;
      test_pin_out <= 6'h00;
      test_pin_oe_n <= 6'h3F;
      chroma_from_test_inputs <= 1'b0;
      chroma_from_bus <= 1'b0;
      sync_test_input <= 8'h00;
      caption_test_mode <= 1'b0;
      detection_active_flag <= 1'b0;
      current_standard <= RST_STANDARD;
      shadow_load_enable <= 1'b1;
    end
    else
    begin
      video_data_bus_out <= tif.vd_o;
      video_data_bus_oe_n <= tif.vd_oe_n;
      horizontal_active_pin <= tif.ha_o;
      hsync_pin <= tif.hs_o;
      vertical_active_pin <= tif.va_o;
      vsync_pin <= tif.vs_o;
      test_pin_out <= tif.tpin_o;
      test_pin_oe_n <= tif.tpin_oe_n;
      chroma_from_test_inputs <= tif.sel_ext_chroma;
      chroma_from_bus <= tif.take_vd_chroma;
      sync_test_input <= code_dig ? tsel_sync : 8'h00;
      caption_test_mode <= (test_control == 8'h05);
      detection_active_flag <= (next_det_state == VDC_DET_RUN);
      current_standard <= next_applied;
      shadow_load_enable <= !shadow_disable;
    end
  end
  // ==========================================================
  // checks
  a_trigger_starts_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (trigger && det_state == VDC_DET_IDLE) |=> (det_state == VDC_DET_RUN) ##1 detection_active_flag)
    else $error("detection run did not start");
  a_trigger_self_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_STANDARD_RECOGNITION) |=> !reg_rdata[7])
    else $error("trigger bit read as one");
  a_status_bit_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_STANDARD_SELECTION) |=> reg_rdata[7] == $past(det_state == VDC_DET_RUN))
    else $error("busy bit wrong");
  a_forced_standard: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_sel && reg_wdata[2:0] != STD_AUTO) |=> ##1 current_standard == $past(reg_wdata[2:0], 2))
    else $error("forced standard not applied");
  a_gp_read_mirror: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_GENERAL_PURPOSE_PORT && eight_bit_mode) |=> reg_rdata[7:4] == $past(vd_sync[7:4]))
    else $error("port input bits wrong");
  a_gain_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_mgain |=> manual_gain_value[7:0] == $past(reg_wdata))
    else $error("manual gain not written");
  a_clamp_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_clamp |=> {clamp_end_time, clamp_start_time} == $past(reg_wdata))
    else $error("clamp timing not written");
  a_dac_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (test_control == 8'h07) [*2] |-> horizontal_active_pin == $past(bandgap_output))
    else $error("bandgap not on active pin");
endmodule : vdc_ctrl_regs

// file: tb_vdc_ctrl_regs.sv
`timescale 1ns/10ps
module tb_vdc_ctrl_regs;
  import vdc_pkg::*;
  // ==========================================================
  // stimulus and wiring
  localparam int DLEN = 20;
  logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, caption_byte_half = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, caption_byte = 8'h5A, test_select_pin_in = 8'hC3;
  logic [6:0] caption_status_other = 7'h55, detected_standard_valid = 7'h7F;
  logic [2:0] detected_standard = 3'h2;
  logic detect_done = 1'b0, output_format_register = 1'b0, bandgap_output = 1'b1, delayed_vertical_sync = 1'b1;
  logic [15:0] video_data_bus_in = 16'h00A0;
  logic [9:0] luma_adc = 10'h2B6, chroma_adc = 10'h1C9;
  logic [7:0] luma_out = 8'h3D, chroma_out = 8'hE4;
  logic [5:0] sync_test_out = 6'h2D;
  logic ha_core = 1'b0, hs_core = 1'b1, va_core = 1'b1, vs_core = 1'b0;
  logic [7:0] reg_rdata, sync_test_input, rd_v;
  logic [15:0] video_data_bus_out, video_data_bus_oe_n;
  logic horizontal_active_pin, hsync_pin, vertical_active_pin, vsync_pin;
  logic [5:0] test_pin_out, test_pin_oe_n;
  logic chroma_from_test_inputs, chroma_from_bus, caption_test_mode, detection_active_flag, shadow_load_enable;
  logic [2:0] current_standard, peak_loop_gain;
  logic [3:0] clamp_end_time, clamp_start_time, normal_loop_max_correction;
  logic [8:0] manual_gain_value;
  int bad_count = 0;
  int checks = 0;

  always #25 ref_clk = ~ref_clk;

  vdc_ctrl_regs #(.DETECT_LEN(DLEN)) DUT
  (
    .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .caption_byte, .caption_byte_half,
    .caption_status_other, .detected_standard_valid, .detected_standard, .detect_done, .output_format_register,
    .video_data_bus_in, .test_select_pin_in, .luma_adc, .chroma_adc, .luma_out, .chroma_out, .sync_test_out,
    .bandgap_output, .delayed_vertical_sync, .ha_core, .hs_core, .va_core, .vs_core, .video_data_bus_out,
    .video_data_bus_oe_n, .horizontal_active_pin, .hsync_pin, .vertical_active_pin, .vsync_pin, .test_pin_out,
    .test_pin_oe_n, .chroma_from_test_inputs, .chroma_from_bus, .sync_test_input, .caption_test_mode,
    .detection_active_flag, .current_standard, .shadow_load_enable, .clamp_end_time, .clamp_start_time,
    .normal_loop_max_correction, .peak_loop_gain, .manual_gain_value
  );

  // ==========================================================
  // bus tasks and comparison
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
    chk(rd_v, exp);
  endtask : rdc

  task automatic pulse_done();
    @(posedge ref_clk);
    detect_done <= 1'b1;
    @(posedge ref_clk);
    detect_done <= 1'b0;
  endtask : pulse_done

  task automatic tmode(input logic [7:0] c);
    wr(OFS_TEST_CONTROL, c);
    cyc(4);
    rdc(OFS_TEST_CONTROL, c);
  endtask : tmode

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // ==========================================================
  // tests
  initial
  begin
    #(50 * 20000);
    bad_count++;
    finish_test();
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(3);
    rdc(OFS_STANDARD_SELECTION, 8'h00);
    rdc(OFS_STANDARD_RECOGNITION, 8'h00);
    rdc(OFS_GENERAL_PURPOSE_PORT, 8'hA0);
    rdc(OFS_CLAMP_TIMING, 8'hA0);
    rdc(OFS_GAIN_LOOP_CONTROL, 8'h22);
    rdc(OFS_MANUAL_GAIN_LOW, 8'hF0);
    chk(manual_gain_value, RST_MANUAL_GAIN);
    rdc(8'h30, 8'h00);
    wr(OFS_CAPTION_DATA, 8'h11);
    rdc(OFS_CAPTION_DATA, 8'h5A);
    wr(OFS_CAPTION_STATUS, 8'h00);
    rdc(OFS_CAPTION_STATUS, 8'hAB);
    // flip the half flag and the byte so a stuck register cannot pass
    @(posedge ref_clk);
    caption_byte_half <= 1'b0;
    caption_byte <= 8'hC3;
    rdc(OFS_CAPTION_STATUS, 8'hAA);
    rdc(OFS_CAPTION_DATA, 8'hC3);
    $display("test reset_values done");
    for (int i = 0; i < 7; i++)
    begin
      wr(OFS_STANDARD_SELECTION, {5'h01, i[2:0]});
      cyc(3);
      chk(current_standard, i[2:0]);
      chk(shadow_load_enable, 1'b0);
      rdc(OFS_STANDARD_SELECTION, {1'b0, i[2:0], 1'b1, i[2:0]});
    end
    wr(OFS_STANDARD_SELECTION, {5'h00, STD_AUTO});
    wr(OFS_STANDARD_RECOGNITION, 8'hFF);
    cyc(2);
    chk(detection_active_flag, 1'b1);
    // busy, last forced standard still applied, shadow on, auto selected
    rdc(OFS_STANDARD_SELECTION, 8'hE7);
    chk(rd_v[7], 1'b1);
    rdc(OFS_STANDARD_RECOGNITION, 8'h7F);
    pulse_done();
    cyc(3);
    chk(detection_active_flag, 1'b0);
    rdc(OFS_STANDARD_SELECTION, 8'h27);
    chk(shadow_load_enable, 1'b1);
    // secam no longer recognised, so the same result must read as not valid
    wr(OFS_STANDARD_RECOGNITION, 8'hFB);
    cyc(2);
    pulse_done();
    cyc(3);
    chk(current_standard, STD_INVALID);
    wr(OFS_STANDARD_RECOGNITION, 8'h80);
    cyc(DLEN - 8);
    chk(detection_active_flag, 1'b1);
    cyc(12);
    chk(detection_active_flag, 1'b0);
    $display("test detection done");
    wr(OFS_GENERAL_PURPOSE_PORT, 8'hF5);
    @(posedge ref_clk);
    video_data_bus_in <= 16'h0060;
    cyc(4);
    chk(video_data_bus_out[3:0], 4'h5);
    chk(video_data_bus_oe_n[3:0], 4'h0);
    rdc(OFS_GENERAL_PURPOSE_PORT, 8'h65);
    @(posedge ref_clk);
    output_format_register <= 1'b1;
    cyc(4);
    rdc(OFS_GENERAL_PURPOSE_PORT, 8'h05);
    chk(video_data_bus_out[3:0], chroma_out[3:0]);
    $display("test port done");
    for (int c = 1; c <= 3; c += 2)
    begin
      tmode(c[7:0]);
      chk({horizontal_active_pin, hsync_pin, video_data_bus_out[15:8]}, {luma_adc[1:0], luma_adc[9:2]});
      chk({vertical_active_pin, vsync_pin, video_data_bus_out[7:0]}, {chroma_adc[1:0], chroma_adc[9:2]});
      chk(chroma_from_test_inputs, c == 3);
    end
    tmode(8'h02);
    chk(sync_test_input, test_select_pin_in);
    tmode(8'h04);
    chk({chroma_from_bus, sync_test_input}, {1'b1, test_select_pin_in});
    chk(video_data_bus_oe_n[7:0], 8'hFF);
    tmode(8'h05);
    chk(caption_test_mode, 1'b1);
    tmode(8'h06);
    chk({vertical_active_pin, vsync_pin, video_data_bus_out[7:0]}, {chroma_adc[1:0], chroma_adc[9:2]});
    tmode(8'h07);
    chk({test_pin_out, test_pin_oe_n}, {sync_test_out, 6'h00});
    chk(video_data_bus_out, {luma_out, chroma_out});
    chk({horizontal_active_pin, vertical_active_pin}, {bandgap_output, delayed_vertical_sync});
    tmode(8'h00);
    chk({test_pin_oe_n, caption_test_mode}, {6'h3F, 1'b0});
    chk({horizontal_active_pin, hsync_pin, vertical_active_pin, vsync_pin}, {ha_core, hs_core, va_core, vs_core});
    $display("test modes done");
    wr(OFS_CLAMP_TIMING, 8'h5C);
    wr(OFS_GAIN_LOOP_CONTROL, 8'hB7);
    wr(OFS_MANUAL_GAIN_LOW, 8'h3C);
    cyc(2);
    chk({clamp_end_time, clamp_start_time}, 8'h5C);
    chk({normal_loop_max_correction, peak_loop_gain}, 7'h5B);
    chk(manual_gain_value, 9'h13C);
    rdc(OFS_GAIN_LOOP_CONTROL, 8'hB7);
    rdc(OFS_MANUAL_GAIN_LOW, 8'h3C);
    // a second reset in mid-run must bring the settings back
    @(posedge ref_clk);
    rst_n <= 1'b0;
    cyc(2);
    chk({clamp_end_time, clamp_start_time}, {RST_CLAMP_END, RST_CLAMP_START});
    chk(manual_gain_value, RST_MANUAL_GAIN);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(3);
    rdc(OFS_GAIN_LOOP_CONTROL, 8'h22);
    $display("test gain_clamp done");
    finish_test();
  end
endmodule : tb_vdc_ctrl_regs
